// ---- hdl/bfm_brake_supervisor.v ----
// brake handshake supervisor and input terminal function mapper
// assumes synchronous inputs and a sequencer that makes the release command
`timescale 1ns/1ps
`default_nettype none
`include "bfm_regs.vh"

module bfm_brake_supervisor #(
   parameter P_CYC_PER_TICK = `BFM_CLK_HZ / 1000000 * `BFM_TICK_US,
   parameter [`BFM_WINDOW_W-1:0] P_WINDOW_MS = `BFM_WINDOW_MS
) (
   input wire i_sys_clk,
   input wire i_rst,
   input wire [`BFM_TERM_N-1:0] i_term,
   input wire i_sel_wr_en,
   input wire [2:0] i_sel_wr_idx,
   input wire [`BFM_CODE_W-1:0] i_sel_wr_data,
   input wire [15:0] i_user_group_read_setting,
   input wire [1:0] i_remote_function_setting,
   input wire i_stop_on_contact_setting,
   input wire i_brake_mode,
   input wire i_brake_release_cmd,
   input wire [15:0] i_ramp_time_ms,
   input wire [15:0] i_current_detect_time_ms,
   output reg o_brake_release_request,
   output reg o_tripped,
   output reg o_fault_no_brake_request,
   output reg o_fault_no_release_feedback,
   output reg o_fault_feedback_lost,
   output reg o_fault_feedback_stuck,
   output reg o_forward_run_input,
   output reg o_reverse_run_input,
   output reg o_low_speed_input,
   output reg o_middle_speed_input,
   output reg o_high_speed_input,
   output reg o_second_set_input,
   output reg o_output_stop_input,
   output reg o_drive_reset_input,
   output reg o_drive_enable_input,
   output reg o_brake_released_feedback,
   output reg o_remote_clear,
   output reg o_remote_decel,
   output reg o_remote_accel,
   output reg o_soc_bit0,
   output reg o_soc_bit1
);

   // tick count held in 14 bits, so a tick may be at most 16384 cycles long
   localparam integer LP_CYC_LAST = P_CYC_PER_TICK - 1;
   localparam [13:0] LP_CNT_MAX = LP_CYC_LAST[13:0];

   reg [`BFM_CODE_W-1:0] sel_code_ff [0:`BFM_TERM_N-1];
   reg [13:0] tick_cnt_ff;
   reg tick_ff;
   reg start_ff;
   reg req_ff;
   reg fb_seen_ff;
   wire [`BFM_TERM_N-1:0] hit_low, hit_mid, hit_high, hit_sec;
   wire [`BFM_TERM_N-1:0] hit_fwd, hit_rev, hit_stop, hit_rst, hit_en, hit_fb;
   wire fn_low, fn_mid, fn_high, fn_sec, remote_on;
   wire start_now, fb_now, t1_exp, t2_exp, t4_exp, ramp_long;
   wire nxt_no_req, nxt_no_fb, nxt_lost, nxt_stuck, any_new;

   // ========================================================
   // millisecond timebase
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         tick_cnt_ff <= 14'h0000;
         tick_ff <= 1'b0;
      end else if (tick_cnt_ff == LP_CNT_MAX) begin
         tick_cnt_ff <= 14'h0000;
         tick_ff <= 1'b1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 14'h0001;
         tick_ff <= 1'b0;
      end
   end

   // ========================================================
   // selection codes, locked unless the user group setting is open
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         sel_code_ff[`BFM_T_FWD] <= `BFM_FN_FWD;
         sel_code_ff[`BFM_T_REV] <= `BFM_FN_REV;
         sel_code_ff[`BFM_T_LOW] <= `BFM_FN_LOW;
         sel_code_ff[`BFM_T_MID] <= `BFM_FN_MID;
         sel_code_ff[`BFM_T_HIGH] <= `BFM_FN_HIGH;
         sel_code_ff[`BFM_T_STOP] <= `BFM_FN_OUT_STOP;
         sel_code_ff[`BFM_T_RST] <= `BFM_FN_RESET;
      end else if (i_sel_wr_en && (i_user_group_read_setting == `BFM_USER_GROUP_OPEN)
                   && (i_sel_wr_idx < `BFM_TERM_N)) begin
         sel_code_ff[i_sel_wr_idx] <= i_sel_wr_data;
      end
   end

   // ========================================================
   // per-terminal code match; unlisted codes simply match nothing
   genvar g;
   generate
      for (g = 0; g < `BFM_TERM_N; g = g + 1) begin : g_term
         assign hit_low[g] = i_term[g] && (sel_code_ff[g] == `BFM_FN_LOW);
         assign hit_mid[g] = i_term[g] && (sel_code_ff[g] == `BFM_FN_MID);
         assign hit_high[g] = i_term[g] && (sel_code_ff[g] == `BFM_FN_HIGH);
         assign hit_sec[g] = i_term[g] && (sel_code_ff[g] == `BFM_FN_SECOND);
         assign hit_fwd[g] = i_term[g] && (sel_code_ff[g] == `BFM_FN_FWD);
         assign hit_rev[g] = i_term[g] && (sel_code_ff[g] == `BFM_FN_REV);
         assign hit_stop[g] = i_term[g] && (sel_code_ff[g] == `BFM_FN_OUT_STOP);
         assign hit_rst[g] = i_term[g] && (sel_code_ff[g] == `BFM_FN_RESET);
         assign hit_en[g] = i_term[g] && (sel_code_ff[g] == `BFM_FN_ENABLE);
         assign hit_fb[g] = i_term[g] && (sel_code_ff[g] == `BFM_FN_BRAKE_FB);
      end
   endgenerate

   // shared codes OR together
   assign fn_low = |hit_low;
   assign fn_mid = |hit_mid;
   assign fn_high = |hit_high;
   assign fn_sec = |hit_sec;
   assign remote_on = (i_remote_function_setting == `BFM_REMOTE_1)
                      || (i_remote_function_setting == `BFM_REMOTE_2);
   assign start_now = |(hit_fwd | hit_rev);
   assign fb_now = |hit_fb;

   // ========================================================
   // function outputs; one registered stage keeps every path far under 2 ms
   // stop-on-contact takes code 0 ahead of remote mode when both are set
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_forward_run_input <= 1'b0;
         o_reverse_run_input <= 1'b0;
         o_low_speed_input <= 1'b0;
         o_middle_speed_input <= 1'b0;
         o_high_speed_input <= 1'b0;
         o_second_set_input <= 1'b0;
         o_output_stop_input <= 1'b0;
         o_drive_reset_input <= 1'b0;
         o_drive_enable_input <= 1'b0;
         o_brake_released_feedback <= 1'b0;
         o_remote_clear <= 1'b0;
         o_remote_decel <= 1'b0;
         o_remote_accel <= 1'b0;
         o_soc_bit0 <= 1'b0;
         o_soc_bit1 <= 1'b0;
      end else begin
         o_forward_run_input <= |hit_fwd;
         o_reverse_run_input <= |hit_rev;
         o_low_speed_input <= fn_low && !remote_on && !i_stop_on_contact_setting;
         o_remote_clear <= fn_low && remote_on && !i_stop_on_contact_setting;
         o_soc_bit0 <= fn_low && i_stop_on_contact_setting;
         o_middle_speed_input <= fn_mid && !remote_on;
         o_remote_decel <= fn_mid && remote_on;
         o_high_speed_input <= fn_high && !remote_on;
         o_remote_accel <= fn_high && remote_on;
         o_second_set_input <= fn_sec && !i_stop_on_contact_setting;
         o_soc_bit1 <= fn_sec && i_stop_on_contact_setting;
         o_output_stop_input <= |hit_stop;
         o_drive_enable_input <= |hit_en;
         o_drive_reset_input <= |hit_rst;
         o_brake_released_feedback <= fb_now;
      end
   end

   // ========================================================
   // edge history and feedback-seen flag for the handshake
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         start_ff <= 1'b0;
         req_ff <= 1'b0;
         fb_seen_ff <= 1'b0;
      end else begin
         start_ff <= start_now;
         req_ff <= o_brake_release_request;
         if (!o_brake_release_request) begin
            fb_seen_ff <= 1'b0;
         end else if (fb_now) begin
            fb_seen_ff <= 1'b1;
         end
      end
   end

   // ========================================================
   // supervision windows
   bfm_window_timer #(.P_LIMIT(P_WINDOW_MS)) u_t_req (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_tick(tick_ff),
      .i_restart(start_now && !start_ff),
      .i_run(start_now && !o_brake_release_request),
      .o_expired(t1_exp)
   );

   bfm_window_timer #(.P_LIMIT(P_WINDOW_MS)) u_t_fb (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_tick(tick_ff),
      .i_restart(o_brake_release_request && !req_ff),
      .i_run(o_brake_release_request && !fb_seen_ff && !fb_now),
      .o_expired(t2_exp)
   );

   bfm_window_timer #(.P_LIMIT(P_WINDOW_MS)) u_t_stuck (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_tick(tick_ff),
      .i_restart(!o_brake_release_request && req_ff),
      .i_run(!o_brake_release_request && fb_now && !start_now),
      .o_expired(t4_exp)
   );

   // ========================================================
   // fault causes, only while brake sequence mode is selected
   assign ramp_long = ({1'b0, i_ramp_time_ms} + {1'b0, i_current_detect_time_ms})
                      > {5'h00, P_WINDOW_MS};
   assign nxt_no_req = i_brake_mode && (t1_exp
                       || (start_now && !start_ff && ramp_long));
   assign nxt_no_fb = i_brake_mode && t2_exp;
   assign nxt_lost = i_brake_mode && o_brake_release_request
                     && fb_seen_ff && !fb_now;
   assign nxt_stuck = i_brake_mode && t4_exp;
   assign any_new = nxt_no_req || nxt_no_fb || nxt_lost || nxt_stuck;

   // ========================================================
   // sticky faults and trip; a new fault wins over the reset function
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_tripped <= 1'b0;
         o_fault_no_brake_request <= 1'b0;
         o_fault_no_release_feedback <= 1'b0;
         o_fault_feedback_lost <= 1'b0;
         o_fault_feedback_stuck <= 1'b0;
         o_brake_release_request <= 1'b0;
      end else begin
         o_fault_no_brake_request <= nxt_no_req
                                     || (o_fault_no_brake_request && !o_drive_reset_input);
         o_fault_no_release_feedback <= nxt_no_fb
                                        || (o_fault_no_release_feedback && !o_drive_reset_input);
         o_fault_feedback_lost <= nxt_lost
                                  || (o_fault_feedback_lost && !o_drive_reset_input);
         o_fault_feedback_stuck <= nxt_stuck
                                   || (o_fault_feedback_stuck && !o_drive_reset_input);
         o_tripped <= any_new || (o_tripped && !o_drive_reset_input);
         // release request is dropped in the very cycle a fault is found
         o_brake_release_request <= i_brake_release_cmd && !any_new
                                    && !o_tripped;
      end
   end

endmodule // bfm_brake_supervisor
`default_nettype wire

// ---- hdl/bfm_regs.vh ----
// constants for the brake fault supervisor and input terminal mapper
// assumes one 10 MHz system clock; included by bare name
`ifndef BFM_REGS_VH
`define BFM_REGS_VH

// ========================================================
// timing
`define BFM_CLK_HZ 10000000
`define BFM_TICK_US 1000
`define BFM_WINDOW_MS 12'h7d0
`define BFM_WINDOW_W 12

// ========================================================
// terminal selection codes
`define BFM_CODE_W 14
`define BFM_FN_LOW 14'h0000
`define BFM_FN_MID 14'h0001
`define BFM_FN_HIGH 14'h0002
`define BFM_FN_SECOND 14'h0003
`define BFM_FN_ENABLE 14'h000a
`define BFM_FN_BRAKE_FB 14'h000f
`define BFM_FN_OUT_STOP 14'h0018
`define BFM_FN_FWD 14'h003c
`define BFM_FN_REV 14'h003d
`define BFM_FN_RESET 14'h003e

// ========================================================
// terminal indices
`define BFM_TERM_N 7
`define BFM_T_FWD 0
`define BFM_T_REV 1
`define BFM_T_LOW 2
`define BFM_T_MID 3
`define BFM_T_HIGH 4
`define BFM_T_STOP 5
`define BFM_T_RST 6

// ========================================================
// mode settings
`define BFM_REMOTE_OFF 2'h0
`define BFM_REMOTE_1 2'h1
`define BFM_REMOTE_2 2'h2
`define BFM_USER_GROUP_OPEN 16'h0000

`endif

// ---- hdl/bfm_window_timer.v ----
// supervision window timer counting millisecond ticks
// assumes i_tick is a one-cycle pulse from the parent's divider
`timescale 1ns/1ps
`default_nettype none
`include "bfm_regs.vh"

module bfm_window_timer #(
   parameter [`BFM_WINDOW_W-1:0] P_LIMIT = `BFM_WINDOW_MS
) (
   input wire i_sys_clk,
   input wire i_rst,
   input wire i_tick,
   input wire i_restart,
   input wire i_run,
   output reg o_expired
);

   reg [`BFM_WINDOW_W-1:0] cnt_ff;

   // ========================================================
   // window count; restart wins over counting
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         cnt_ff <= {`BFM_WINDOW_W{1'b0}};
         o_expired <= 1'b0;
      end else if (i_restart || !i_run) begin
         cnt_ff <= {`BFM_WINDOW_W{1'b0}};
         o_expired <= 1'b0;
      end else if (i_tick) begin
         // saturate so a long stall never wraps back inside the window
         if (cnt_ff != P_LIMIT) begin
            cnt_ff <= cnt_ff + {{(`BFM_WINDOW_W-1){1'b0}}, 1'b1};
         end
         o_expired <= (cnt_ff == P_LIMIT); // more than the full window
      end
   end

endmodule // bfm_window_timer
`default_nettype wire

// ---- verification/bfm_brake_model.sv ----
// mechanical brake with its released-feedback contact
// assumes the request is a level; contact faults are commanded by the bench
`timescale 1ns/1ps
`default_nettype none
module bfm_brake_model #(
   parameter int P_DLY = 4
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic [1:0] i_fault,
   output logic o_fb
);
   // =========================================
   // contact follows the request after a mechanical delay
   logic [7:0] cnt_ff;
   always @(posedge i_sys_clk) begin
      // 1: contact stays open, 2: contact welded shut
      if (i_rst || i_req == o_fb || i_fault != 2'h0) cnt_ff <= 8'h00; // no wrap while forced
      else cnt_ff <= cnt_ff + 8'h01;
      if (i_rst || i_fault == 2'h1) o_fb <= 1'b0;
      else if (i_fault == 2'h2) o_fb <= 1'b1;
      else if (cnt_ff == P_DLY[7:0]) o_fb <= i_req;
   end
endmodule // bfm_brake_model
`default_nettype wire

// ---- verification/bfm_brake_supervisor_bench.sv ----
// self-checking bench for the brake supervisor and terminal mapper
// assumes short tick and window parameters; brake model on terminal 3
`timescale 1ns/1ps
`default_nettype none
`include "bfm_regs.vh"
module bfm_brake_supervisor_bench;
   // =========================================
   // stimulus and design
   logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, soc = 1'b0, bmode = 1'b0, cmd = 1'b0;
   logic fb_sel = 1'b0, fb, req, trip, en_o, fbo;
   logic [6:0] tb_term = 7'h00;
   logic [2:0] wr_idx = 3'h0;
   logic [13:0] wr_data = 14'h0000;
   logic [15:0] ugr = 16'h0000, ramp = 16'h0000, det = 16'h0000;
   logic [1:0] remote = 2'h0, pfault = 2'h0;
   wire [3:0] flt;
   wire [6:0] dec;
   wire [5:0] ext;
   wire [6:0] term = fb_sel ? {tb_term[6:4], fb, tb_term[2:0]} : tb_term;
   int bad_count = 0, cmp_count = 0;
   always #50 clk = ~clk;
   bfm_brake_supervisor #(.P_CYC_PER_TICK(10), .P_WINDOW_MS(12'h014)) dut (.i_sys_clk(clk),
      .i_rst(rst), .i_term(term), .i_sel_wr_en(wr_en), .i_sel_wr_idx(wr_idx),
      .i_sel_wr_data(wr_data), .i_user_group_read_setting(ugr),
      .i_remote_function_setting(remote), .i_stop_on_contact_setting(soc),
      .i_brake_mode(bmode), .i_brake_release_cmd(cmd), .i_ramp_time_ms(ramp),
      .i_current_detect_time_ms(det), .o_brake_release_request(req), .o_tripped(trip),
      .o_fault_no_brake_request(flt[0]), .o_fault_no_release_feedback(flt[1]),
      .o_fault_feedback_lost(flt[2]), .o_fault_feedback_stuck(flt[3]),
      .o_forward_run_input(dec[0]), .o_reverse_run_input(dec[1]), .o_low_speed_input(dec[2]),
      .o_middle_speed_input(dec[3]), .o_high_speed_input(dec[4]),
      .o_second_set_input(ext[0]), .o_output_stop_input(dec[5]),
      .o_drive_reset_input(dec[6]), .o_drive_enable_input(en_o),
      .o_brake_released_feedback(fbo), .o_remote_clear(ext[1]), .o_remote_decel(ext[2]),
      .o_remote_accel(ext[3]), .o_soc_bit0(ext[4]), .o_soc_bit1(ext[5]));
   bfm_brake_model #(.P_DLY(4)) u_brake (.i_sys_clk(clk), .i_rst(rst), .i_req(req),
      .i_fault(pfault), .o_fb(fb));
   // =========================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // inputs always move 10 ns after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic wr(input logic [2:0] i, input logic [13:0] c);
      wr_en = 1'b1;
      wr_idx = i;
      wr_data = c;
      cyc(1);
      wr_en = 1'b0;
      cyc(1);
   endtask
   // n counts cycles from the cause, so lo and hi bound the window
   task automatic wait_fault(input logic [3:0] exp, input int lo, input int hi);
      int n;
      n = 0;
      while (flt === 4'h0 && n < hi + 20) begin
         cyc(1);
         n++;
      end
      chk(flt, exp);
      chk(n >= lo && n <= hi, 1);
      chk({trip, req}, 2'b10);
   endtask
   // contact repaired first, else the stuck timer would trip again
   task automatic clear_trip;
      tb_term = 7'h00;
      cmd = 1'b0;
      pfault = 2'h0;
      cyc(8);
      tb_term = 7'h40;
      cyc(3);
      tb_term = 7'h00;
      cyc(2);
      chk({trip, flt}, 5'h00);
   endtask
   // =========================================
   // scenarios
   task automatic t_defaults;
      for (int i = 0; i < 7; i++) begin
         tb_term = 7'h01 << i;
         cyc(2);
         chk(dec, 7'h01 << i);
      end
      $display("defaults done");
   endtask
   task automatic t_remap;
      ugr = 16'h0001;
      wr(3'h2, `BFM_FN_SECOND);
      ugr = 16'h0000;
      tb_term = 7'h04;
      cyc(2);
      chk({ext[0], dec}, 8'h04);
      wr(3'h2, `BFM_FN_MID);
      chk(dec, 7'h08);
      tb_term = 7'h0c;
      cyc(2);
      chk(dec, 7'h08);
      wr(3'h2, `BFM_FN_LOW);
      wr(3'h5, `BFM_FN_ENABLE);
      tb_term = 7'h20;
      cyc(2);
      chk({en_o, dec[5]}, 2'b10);
      $display("remap done");
   endtask
   task automatic t_modes;
      tb_term = 7'h1c;
      for (int m = 1; m < 3; m++) begin
         remote = m[1:0];
         cyc(2);
         chk({ext[3:1], dec[4:2]}, 6'b111000);
      end
      remote = 2'h0;
      soc = 1'b1;
      wr(3'h5, `BFM_FN_SECOND);
      tb_term = 7'h24;
      cyc(2);
      chk({ext[5:4], ext[0], dec[2]}, 4'b1100);
      soc = 1'b0;
      cyc(2);
      chk({ext[5:4], ext[0], dec[2]}, 4'b0011);
      wr(3'h5, `BFM_FN_OUT_STOP);
      wr(3'h3, `BFM_FN_BRAKE_FB);
      fb_sel = 1'b1;
      bmode = 1'b1;
      tb_term = 7'h00;
      cyc(8);
      $display("modes done");
   endtask
   task automatic t_start_faults;
      tb_term = 7'h01;
      wait_fault(4'h1, 190, 230);
      clear_trip;
      tb_term = 7'h02;
      cyc(100);
      tb_term = 7'h00;
      cyc(2);
      tb_term = 7'h02;
      wait_fault(4'h1, 190, 230);
      clear_trip;
      // ramp sums are in tick units against the shortened 20-tick window
      ramp = 16'h000f;
      det = 16'h0005;
      tb_term = 7'h01;
      cyc(3);
      cmd = 1'b1;
      cyc(300);
      chk({trip, req, fbo, flt}, 7'h30);
      pfault = 2'h1;
      wait_fault(4'h4, 0, 3);
      clear_trip;
      det = 16'h0006;
      tb_term = 7'h01;
      wait_fault(4'h1, 0, 5);
      clear_trip;
      det = 16'h0000;
      $display("start faults done");
   endtask
   task automatic t_feedback_faults;
      tb_term = 7'h01;
      cmd = 1'b1;
      pfault = 2'h1;
      wait_fault(4'h2, 190, 230);
      clear_trip;
      tb_term = 7'h01;
      cmd = 1'b1;
      cyc(20);
      pfault = 2'h2;
      cmd = 1'b0;
      tb_term = 7'h00;
      wait_fault(4'h8, 190, 230);
      clear_trip;
      bmode = 1'b0;
      tb_term = 7'h01;
      cyc(300);
      chk({trip, flt}, 5'h00);
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      fb_sel = 1'b0;
      tb_term = 7'h08;
      cyc(2);
      chk({fbo, dec}, 8'h08);
      $display("feedback faults done");
   endtask
   // =========================================
   // verdict, main sequence and watchdog
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      cyc(8);
      rst = 1'b0;
      t_defaults;
      t_remap;
      t_modes;
      t_start_faults;
      t_feedback_faults;
      print_verdict;
   end
   // run needs about 1700 cycles; allow over five times that
   initial begin
      #1000000;
      bad_count++;
      print_verdict;
   end
endmodule // bfm_brake_supervisor_bench
`default_nettype wire

// ---- verification/bfm_brake_supervisor_checker.sv ----
// concurrent checks on the brake supervisor top ports
// assumes one clock domain; bound to every supervisor instance
`timescale 1ns/1ps
`default_nettype none
module bfm_brake_checker (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_brake_mode,
   input wire logic i_brake_release_cmd,
   input wire logic o_brake_release_request,
   input wire logic o_tripped,
   input wire logic o_fault_no_brake_request,
   input wire logic o_fault_no_release_feedback,
   input wire logic o_fault_feedback_lost,
   input wire logic o_fault_feedback_stuck,
   input wire logic o_brake_released_feedback,
   input wire logic o_drive_reset_input
);
   // =========================================
   // handshake and fault relations
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   wire any_fault = o_fault_no_brake_request | o_fault_no_release_feedback
      | o_fault_feedback_lost | o_fault_feedback_stuck;
   trip_forces_off_a: assert property (o_tripped |-> !o_brake_release_request)
      else $error("release request on while tripped");
   fault_trips_a: assert property (any_fault |-> o_tripped)
      else $error("fault flag without trip");
   req_follows_a: assert property (o_brake_release_request |-> $past(i_brake_release_cmd))
      else $error("release request without command");
   trip_clear_a: assert property ($fell(o_tripped) |->
      o_drive_reset_input || $past(o_drive_reset_input)) else $error("trip cleared without reset");
   mode_gate_a: assert property ($rose(any_fault) |-> $past(i_brake_mode))
      else $error("fault raised outside brake mode");
   lost_fb_a: assert property ($fell(o_brake_released_feedback) && i_brake_mode &&
      $past(o_brake_release_request) |-> ##[0:1] o_fault_feedback_lost) else $error("lost miss");
   nofb_fault_a: assert property ($rose(o_fault_no_release_feedback) |->
      $past(o_brake_release_request)) else $error("feedback fault without request");
   noreq_fault_a: assert property ($rose(o_fault_no_brake_request) |->
      !$past(o_brake_release_request)) else $error("request fault with request on");
   stuck_fault_a: assert property ($rose(o_fault_feedback_stuck) |->
      !$past(o_brake_release_request) && $past(o_brake_released_feedback))
      else $error("stuck fault without held feedback");
endmodule // bfm_brake_checker
bind bfm_brake_supervisor bfm_brake_checker u_chk (.i_sys_clk, .i_rst, .i_brake_mode,
   .i_brake_release_cmd, .o_brake_release_request, .o_tripped, .o_fault_no_brake_request,
   .o_fault_no_release_feedback, .o_fault_feedback_lost, .o_fault_feedback_stuck,
   .o_brake_released_feedback, .o_drive_reset_input);
`default_nettype wire
